// File: swc_pkg.sv
// Overview of operation
// - Sleep clears watchdog, clears power-down flag, sets time-out flag, stops oscillator.
// - I/O pins hold their pre-sleep drive level or high impedance while asleep.
// - Wake on master clear, watchdog time-out if enabled, or enabled interrupt.
// - Master clear while asleep gives full reset; other wake sources resume execution.
// - A watchdog wake-up clears the time-out flag.
// - Power-down flag sets at power-up and clears only when sleep executes.
// - Peripheral wake sources are the seven asynchronous or clockless peripheral events.
// - Peripherals needing on-chip clocks cannot interrupt while asleep.
// - Executing sleep prefetches the instruction at the next program address.
// - Interrupt wakes only with its own enable set, whatever the global enable.
// - After interrupt wake run next instruction, then vector if global enable set.
// - Enabled pending flag with global enable clear turns sleep into no-operation.
// - Interrupt during or after sleep completes sleep, then wakes immediately.
// - Interrupt response clears global enable and loads vector address.
// - Watchdog time-out in sleep resumes execution without reinitialising registers.
package swc_pkg;

  // ==========================================================================
  // Register map (word addresses)
  localparam int ADDR_W         = 3;
  localparam logic [2:0] OFS_CTRL     = 3'h0;
  localparam logic [2:0] OFS_STATUS   = 3'h1;
  localparam logic [2:0] OFS_WAKE_EN  = 3'h2;
  localparam logic [2:0] OFS_EVT      = 3'h3;
  localparam logic [2:0] OFS_EVT_MASK = 3'h4;
  localparam logic [2:0] OFS_PREFETCH = 3'h5;

  // ==========================================================================
  // Field positions
  localparam int CTRL_WDT_EN    = 0;
  localparam int CTRL_GIE       = 1;
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_OSC       = 2;
  localparam int STAT_PD        = 3;
  localparam int STAT_TO        = 4;

  // Wake sources: 0 interrupt pin, 1 port change, 2..8 the seven peripherals,
  // 9 the clocked peripheral group.
  localparam int N_SRC       = 10;
  localparam int N_PIN_SRC   = 9;
  localparam int SRC_CLOCKED = 9;

  localparam int N_EVT         = 5;
  localparam int EV_SLEPT      = 0;
  localparam int EV_NOP        = 1;
  localparam int EV_WAKE_IRQ   = 2;
  localparam int EV_WAKE_WDT   = 3;
  localparam int EV_MASTER_CLEAR_PIN       = 4;

  // ==========================================================================
  // Reset values
  localparam logic [1:0]       CTRL_RST    = 2'h0;
  localparam logic [N_SRC-1:0] WAKE_EN_RST = 10'h000;
  localparam logic [N_EVT-1:0] EVT_RST     = 5'h00;

  // ==========================================================================
  // Program counter
  localparam int          PC_W     = 13;
  localparam logic [12:0] IRQ_VEC  = 13'h0004;

  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int OSC_START_NS  = 10240;
  localparam int OSC_START_CYC =
    (OSC_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WDT_PERIOD_US = 18000;
  localparam int WDT_CYC       = WDT_PERIOD_US * 1000 / CLK_PERIOD_NS;

  // ==========================================================================
  // Sequencer states
  typedef enum logic [1:0]
  {
    SWC_RUN   = 2'b00,
    SWC_SLEEP = 2'b01,
    SWC_WARM  = 2'b10,
    SWC_EXEC  = 2'b11
  } swc_state_t;

endpackage

// File: swc_sync.sv
`timescale 1ns/100ps
`default_nettype none
module swc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] d,
  input  wire logic [W-1:0] rst_val,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;

  // ==========================================================================
  // Two-stage synchroniser; both stages reset to all ones.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta_r <= '1;
      q      <= '1;
    end
    else
    begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule
`default_nettype wire

// File: swc_wdt.sv
`timescale 1ns/100ps
`default_nettype none
module swc_wdt #(
  parameter int unsigned CYCLES = 1800000
) (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic en,
  input  wire logic clr,
  output logic      timeout
);

  logic [31:0] cnt_r;

  // ==========================================================================
  // Free-running count with postscaler folded in; clearing never stops it.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt_r   <= 32'h0;
      timeout <= 1'b0;
    end
    else if (clr || !en)
    begin
      cnt_r   <= 32'h0;
      timeout <= 1'b0;
    end
    else if (cnt_r == CYCLES - 1)
    begin
      cnt_r   <= 32'h0;
      timeout <= 1'b1;
    end
    else
    begin
      cnt_r   <= cnt_r + 32'h1;
      timeout <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// File: swc_top.sv
// Added by the designer: the register addresses and the Avalon-MM register port.
`timescale 1ns/100ps
`default_nettype none
module swc_top #(
  parameter int unsigned WDT_CYCLES = swc_pkg::WDT_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic [2:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        master_clear_pin_b,
  input  wire logic [8:0]  wake_flag,
  input  wire logic        clocked_irq_flag,
  input  wire logic        sleep_instr,
  input  wire logic        watchdog_clear_instr,
  input  wire logic        instr_done,
  input  wire logic [12:0] pc_in,
  input  wire logic [7:0]  core_io_out,
  input  wire logic [7:0]  core_io_oe,
  output logic      [7:0]  io_pin_out,
  output logic      [7:0]  io_pin_oe,
  output logic             osc_drive_en,
  output logic             core_run,
  output logic      [12:0] prefetch_addr,
  output logic             vector_req,
  output logic      [12:0] vector_addr,
  output logic             full_reset_req,
  output logic             irq
);

  swc_pkg::swc_state_t state_r;
  logic [8:0]  wake_flag_s;
  logic        master_clear_pin_s_b;
  logic        wdt_to;
  logic        wdt_en_r;
  logic        gie_r;
  logic        pd_r;
  logic        to_r;
  logic [swc_pkg::N_SRC-1:0] wake_en_r;
  logic [swc_pkg::N_SRC-1:0] src;
  logic [swc_pkg::N_EVT-1:0] evt_r;
  logic [swc_pkg::N_EVT-1:0] evt_mask_r;
  logic [swc_pkg::N_EVT-1:0] evt_set;
  logic [10:0] osc_cnt_r;
  logic        pending;
  logic        awake;
  logic        sleep_go;
  logic        sleep_nop;
  logic        ack_r;
  logic        wr_en;
  logic [31:0] rd_mux;

  // ==========================================================================
  // Input synchronisers and watchdog
  swc_sync #(.W(9)) u_flag_sync (
    .clk     (clk),
    .rst_b   (rst_b),
    .d       (wake_flag),
    .rst_val (9'h1ff),
    .q       (wake_flag_s)
  );

  swc_sync #(.W(1)) u_master_clear_pin_sync (
    .clk     (clk),
    .rst_b   (rst_b),
    .d       (master_clear_pin_b),
    .rst_val (1'b1),
    .q       (master_clear_pin_s_b)
  );

  swc_wdt #(.CYCLES(WDT_CYCLES)) u_wdt (
    .clk     (clk),
    .rst_b   (rst_b),
    .en      (wdt_en_r),
    .clr     (sleep_go || watchdog_clear_instr || !master_clear_pin_s_b),
    .timeout (wdt_to)
  );

  // ==========================================================================
  // Wake decision
  assign awake = (state_r == swc_pkg::SWC_RUN) || (state_r == swc_pkg::SWC_EXEC);
  assign src   = {clocked_irq_flag && awake, wake_flag_s};
  assign pending   = |(src & wake_en_r);
  assign sleep_nop = (state_r == swc_pkg::SWC_RUN) && sleep_instr
                     && pending && !gie_r && master_clear_pin_s_b;
  assign sleep_go  = (state_r == swc_pkg::SWC_RUN) && sleep_instr
                     && !sleep_nop && master_clear_pin_s_b;
  assign core_run  = awake;
  assign vector_addr = swc_pkg::IRQ_VEC;

  // ==========================================================================
  // Sequencer
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      state_r <= swc_pkg::SWC_RUN;
    else if (!master_clear_pin_s_b)
      state_r <= swc_pkg::SWC_RUN;
    else
    begin
      unique case (state_r)
        swc_pkg::SWC_RUN:
          if (sleep_go)
            state_r <= swc_pkg::SWC_SLEEP;
        swc_pkg::SWC_SLEEP:
          if (pending || wdt_to)
            state_r <= swc_pkg::SWC_WARM;
        swc_pkg::SWC_WARM:
          if (osc_cnt_r == 11'h0)
            state_r <= swc_pkg::SWC_EXEC;
        swc_pkg::SWC_EXEC:
          if (instr_done)
            state_r <= swc_pkg::SWC_RUN;
      endcase
    end
  end

  // Oscillator driver and start-up wait.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      osc_drive_en <= 1'b1;
      osc_cnt_r    <= 11'h0;
    end
    else if (sleep_go)
      osc_drive_en <= 1'b0;
    else if (state_r == swc_pkg::SWC_SLEEP)
    begin
      osc_drive_en <= !master_clear_pin_s_b || pending || wdt_to;
      osc_cnt_r    <= 11'(swc_pkg::OSC_START_CYC - 1);
    end
    else if (state_r == swc_pkg::SWC_WARM && osc_cnt_r != 11'h0)
      osc_cnt_r <= osc_cnt_r - 11'h1;
  end

  // Power-down and time-out flags.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pd_r <= 1'b1;
      to_r <= 1'b1;
    end
    else if (sleep_go)
    begin
      pd_r <= 1'b0;
      to_r <= 1'b1;
    end
    else if (watchdog_clear_instr && awake)
    begin
      pd_r <= 1'b1;
      to_r <= 1'b1;
    end
    else if (wdt_to && master_clear_pin_s_b && state_r != swc_pkg::SWC_WARM)
      to_r <= 1'b0;
  end

  // Core-facing outputs.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      prefetch_addr  <= 13'h0;
      vector_req     <= 1'b0;
      full_reset_req <= 1'b0;
    end
    else
    begin
      if (state_r == swc_pkg::SWC_RUN && sleep_instr)
        prefetch_addr <= pc_in + 13'h1;
      vector_req <= (state_r == swc_pkg::SWC_EXEC) && instr_done
                    && gie_r && master_clear_pin_s_b;
      full_reset_req <= !master_clear_pin_s_b || (awake && wdt_to);
    end
  end

  // Pin state freezes while the core is not running.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      io_pin_out <= 8'h00;
      io_pin_oe  <= 8'h00;
    end
    else if (awake)
    begin
      io_pin_out <= core_io_out;
      io_pin_oe  <= core_io_oe;
    end
  end

  // ==========================================================================
  // Avalon-MM slave: one wait cycle per access
  assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
  assign wr_en = avs_write && ack_r;

  always_comb
  begin
    rd_mux = 32'h0;
    unique case (avs_address)
      swc_pkg::OFS_CTRL:
      begin
        rd_mux[swc_pkg::CTRL_WDT_EN] = wdt_en_r;
        rd_mux[swc_pkg::CTRL_GIE]    = gie_r;
      end
      swc_pkg::OFS_STATUS:
      begin
        rd_mux[swc_pkg::STAT_STATE_LSB +: 2] = state_r;
        rd_mux[swc_pkg::STAT_OSC] = osc_drive_en;
        rd_mux[swc_pkg::STAT_PD]  = pd_r;
        rd_mux[swc_pkg::STAT_TO]  = to_r;
      end
      swc_pkg::OFS_WAKE_EN:  rd_mux[swc_pkg::N_SRC-1:0] = wake_en_r;
      swc_pkg::OFS_EVT:      rd_mux[swc_pkg::N_EVT-1:0] = evt_r;
      swc_pkg::OFS_EVT_MASK: rd_mux[swc_pkg::N_EVT-1:0] = evt_mask_r;
      swc_pkg::OFS_PREFETCH: rd_mux[swc_pkg::PC_W-1:0]  = prefetch_addr;
      default:               rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ack_r        <= 1'b0;
      avs_readdata <= 32'h0;
    end
    else
    begin
      ack_r <= (avs_read || avs_write) && !ack_r;
      if (avs_read && !ack_r)
        avs_readdata <= rd_mux;
    end
  end

  // Control registers; vectoring clears the global enable over software.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wdt_en_r   <= swc_pkg::CTRL_RST[swc_pkg::CTRL_WDT_EN];
      gie_r      <= swc_pkg::CTRL_RST[swc_pkg::CTRL_GIE];
      wake_en_r  <= swc_pkg::WAKE_EN_RST;
      evt_mask_r <= swc_pkg::EVT_RST;
    end
    else
    begin
      if (wr_en && avs_address == swc_pkg::OFS_CTRL)
      begin
        wdt_en_r <= avs_writedata[swc_pkg::CTRL_WDT_EN];
        gie_r    <= avs_writedata[swc_pkg::CTRL_GIE];
      end
      if (state_r == swc_pkg::SWC_EXEC && instr_done && gie_r)
        gie_r <= 1'b0;
      if (wr_en && avs_address == swc_pkg::OFS_WAKE_EN)
        wake_en_r <= avs_writedata[swc_pkg::N_SRC-1:0];
      if (wr_en && avs_address == swc_pkg::OFS_EVT_MASK)
        evt_mask_r <= avs_writedata[swc_pkg::N_EVT-1:0];
    end
  end

  // ==========================================================================
  // Event status, write one to clear, set wins
  always_comb
  begin
    evt_set = '0;
    evt_set[swc_pkg::EV_SLEPT] = sleep_go;
    evt_set[swc_pkg::EV_NOP]   = sleep_nop;
    evt_set[swc_pkg::EV_WAKE_IRQ] =
      (state_r == swc_pkg::SWC_SLEEP) && master_clear_pin_s_b && pending;
    evt_set[swc_pkg::EV_WAKE_WDT] =
      (state_r == swc_pkg::SWC_SLEEP) && master_clear_pin_s_b && !pending && wdt_to;
    evt_set[swc_pkg::EV_MASTER_CLEAR_PIN] = (state_r == swc_pkg::SWC_SLEEP) && !master_clear_pin_s_b;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      evt_r <= swc_pkg::EVT_RST;
    else if (wr_en && avs_address == swc_pkg::OFS_EVT)
      evt_r <= (evt_r & ~avs_writedata[swc_pkg::N_EVT-1:0]) | evt_set;
    else
      evt_r <= evt_r | evt_set;
  end

  assign irq = |(evt_r & evt_mask_r);

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_sleep_entry_flags: assert property (sleep_go |=> !pd_r && to_r && !osc_drive_en && state_r == swc_pkg::SWC_SLEEP) else $error("sleep entry flags wrong");
  a_osc_off_sleep: assert property ($past(state_r) == swc_pkg::SWC_SLEEP && state_r == swc_pkg::SWC_SLEEP |-> !osc_drive_en) else $error("oscillator on in sleep");
  a_io_held_sleep: assert property (state_r == swc_pkg::SWC_SLEEP ##1 state_r == swc_pkg::SWC_SLEEP |-> $stable(io_pin_out) && $stable(io_pin_oe)) else $error("pins moved in sleep");
  a_irq_wake_now: assert property (state_r == swc_pkg::SWC_SLEEP && pending && master_clear_pin_s_b |=> state_r == swc_pkg::SWC_WARM && osc_drive_en) else $error("no interrupt wake");
  a_master_clear_pin_full_reset: assert property (state_r == swc_pkg::SWC_SLEEP && !master_clear_pin_s_b |=> full_reset_req && state_r == swc_pkg::SWC_RUN) else $error("master clear missed");
  a_wdt_wake_to: assert property (state_r == swc_pkg::SWC_SLEEP && wdt_to && master_clear_pin_s_b |=> !to_r && state_r == swc_pkg::SWC_WARM && !full_reset_req) else $error("watchdog wake wrong");
  a_pd_fall_cause: assert property ($fell(pd_r) |-> $past(sleep_go)) else $error("power-down flag cleared without sleep");
  a_clocked_quiet: assert property (state_r == swc_pkg::SWC_SLEEP && master_clear_pin_s_b && !wdt_to && !(|(wake_flag_s & wake_en_r[8:0])) |=> state_r == swc_pkg::SWC_SLEEP) else $error("clocked peripheral woke core");
  a_prefetch_next: assert property (state_r == swc_pkg::SWC_RUN && sleep_instr |=> prefetch_addr == $past(pc_in) + 13'h1) else $error("prefetch address wrong");
  a_vector_gie: assert property (state_r == swc_pkg::SWC_EXEC && instr_done && gie_r && master_clear_pin_s_b |=> vector_req && !gie_r && vector_addr == 13'h0004) else $error("vector not taken");
  a_sleep_nop: assert property (sleep_nop && !watchdog_clear_instr |=> state_r == swc_pkg::SWC_RUN && pd_r == $past(pd_r) && to_r == $past(to_r)) else $error("sleep not a no-op");
  a_warm_wait: assert property ($rose(state_r == swc_pkg::SWC_WARM) |-> (state_r == swc_pkg::SWC_WARM && osc_drive_en && !core_run)[*8]) else $error("resumed before clock stable");

  c_wdt_wake: cover property (state_r == swc_pkg::SWC_SLEEP && wdt_to ##1 state_r == swc_pkg::SWC_WARM);
  c_irq_vector: cover property (vector_req);
  c_sleep_nop: cover property (sleep_nop);
  c_master_clear_pin_sleep: cover property (state_r == swc_pkg::SWC_SLEEP && !master_clear_pin_s_b);

endmodule
`default_nettype wire

// File: swc_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module swc_host_model (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        core_run,
  output logic             sleep_instr,
  output logic             watchdog_clear_instr,
  output logic             instr_done,
  output logic      [12:0] pc_in,
  output logic      [7:0]  core_io_out,
  output logic      [7:0]  core_io_oe
);
  logic       run_q;
  logic [1:0] done_cnt;
  logic [7:0] io_cnt_r;
  logic [7:0] exp_io;

  initial
  begin
    sleep_instr          = 1'b0;
    watchdog_clear_instr = 1'b0;
    pc_in                = 13'h0000;
    exp_io               = 8'h00;
  end

  // ==========================================================================
  // Pin drive
  // The core changes its pins every cycle, asleep or not.
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      io_cnt_r <= 8'h00;
    else
      io_cnt_r <= io_cnt_r + 8'h01;
  assign core_io_out = io_cnt_r;
  assign core_io_oe  = ~io_cnt_r;

  // ==========================================================================
  // Instruction after sleep
  // It is a no-operation that ends three cycles after the core resumes.
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      run_q      <= 1'b1;
      done_cnt   <= 2'h0;
      instr_done <= 1'b0;
    end
    else
    begin
      run_q      <= core_run;
      done_cnt   <= (core_run & ~run_q) ? 2'h2 :
                    (done_cnt != 2'h0) ? done_cnt - 2'h1 : 2'h0;
      instr_done <= (done_cnt == 2'h1);
    end

  // ==========================================================================
  // Software
  // Pin levels seen by the pad register at the edge that takes sleep.
  task automatic do_sleep(input logic [12:0] pc);
    @(posedge clk);
    pc_in       <= pc;
    sleep_instr <= 1'b1;
    exp_io      <= io_cnt_r + 8'h01;
    @(posedge clk);
    sleep_instr <= 1'b0;
  endtask

  task automatic do_watchdog_clear_instr;
    @(posedge clk);
    watchdog_clear_instr <= 1'b1;
    @(posedge clk);
    watchdog_clear_instr <= 1'b0;
  endtask
endmodule
`default_nettype wire

// File: testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  localparam int unsigned WDT_N = 200;
  logic        clk, rst_b, avs_read, avs_write, avs_waitrequest, irq;
  logic        master_clear_pin_b, clocked_irq_flag, sleep_instr;
  logic        watchdog_clear_instr, instr_done, osc_drive_en, core_run;
  logic        vector_req, full_reset_req;
  logic [2:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [8:0]  wake_flag;
  logic [12:0] pc_in, prefetch_addr, vector_addr;
  logic [7:0]  core_io_out, core_io_oe, io_pin_out, io_pin_oe;
  int          n_errors, checks, cyc, n, vec_cnt;

  swc_top #(.WDT_CYCLES(WDT_N)) i_dut (
    .clk(clk), .rst_b(rst_b), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .master_clear_pin_b(master_clear_pin_b), .wake_flag(wake_flag),
    .clocked_irq_flag(clocked_irq_flag), .sleep_instr(sleep_instr),
    .watchdog_clear_instr(watchdog_clear_instr),
    .instr_done(instr_done), .pc_in(pc_in),
    .core_io_out(core_io_out), .core_io_oe(core_io_oe),
    .io_pin_out(io_pin_out), .io_pin_oe(io_pin_oe),
    .osc_drive_en(osc_drive_en), .core_run(core_run),
    .prefetch_addr(prefetch_addr), .vector_req(vector_req),
    .vector_addr(vector_addr), .full_reset_req(full_reset_req),
    .irq(irq)
  );

  swc_host_model i_host (
    .clk(clk), .rst_b(rst_b), .core_run(core_run),
    .sleep_instr(sleep_instr),
    .watchdog_clear_instr(watchdog_clear_instr),
    .instr_done(instr_done), .pc_in(pc_in),
    .core_io_out(core_io_out), .core_io_oe(core_io_oe)
  );

  // ==========================================================================
  // Clock, vector pulse count and hang limit
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (vector_req === 1'b1)
      vec_cnt <= vec_cnt + 1;
    if (cyc == 40000)
    begin
      n_errors = n_errors + 1;
      end_of_test();
    end
  end

  // ==========================================================================
  // Tasks
  task automatic end_of_test;
    if (n_errors == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks = checks + 1;
    if (seen !== exp)
    begin
      n_errors = n_errors + 1;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One bus transfer; the request holds until the rising edge at which
  // waitrequest is sampled low, and read data is taken at that edge.
  task automatic bus_io(input logic w, input logic [2:0] a,
                        input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= w;
    avs_read      <= ~w;
    do
      @(posedge clk);
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask

  task automatic wr(input logic [2:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus_io(1'b1, a, d, q);
  endtask

  task automatic rdchk(input logic [2:0] a, input logic [31:0] e,
                       input string nm);
    bus_io(1'b0, a, 32'h0, rd);
    chk(nm, rd, e);
  endtask

  // Counts falling edges until the core runs (sel high) or the oscillator
  // is on, then returns on the next rising edge.
  task automatic wait_hi(input int lim, input logic sel);
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (((sel ? core_run : osc_drive_en) !== 1'b1) && n < lim);
    @(posedge clk);
  endtask

  // ==========================================================================
  // Tests
  initial
  begin
    rst_b              = 1'b0;
    avs_read           = 1'b0;
    avs_write          = 1'b0;
    avs_address        = 3'h0;
    avs_writedata      = 32'h0;
    master_clear_pin_b = 1'b1;
    wake_flag          = 9'h000;
    clocked_irq_flag   = 1'b0;
    n_errors           = 0;
    checks             = 0;
    cyc                = 0;
    vec_cnt            = 0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    rdchk(swc_pkg::OFS_STATUS, 32'h1c, "status");
    rdchk(swc_pkg::OFS_CTRL, 32'h0, "ctrl");
    rdchk(swc_pkg::OFS_WAKE_EN, 32'h0, "wake_en");
    wr(3'h6, 32'hffff);
    rdchk(3'h6, 32'h0, "unmapped");
    wr(swc_pkg::OFS_EVT_MASK, 32'h1f);
    // Interrupt wake with the global enable clear.
    wr(swc_pkg::OFS_WAKE_EN, 32'h001);
    i_host.do_sleep(13'h0123);
    repeat (40) @(negedge clk);
    chk("pins", {io_pin_oe, io_pin_out},
        {~i_host.exp_io, i_host.exp_io});
    chk("osc", osc_drive_en, 1'b0);
    chk("irq", irq, 1'b1);
    rdchk(swc_pkg::OFS_STATUS, 32'h11, "status");
    rdchk(swc_pkg::OFS_PREFETCH, 32'h124, "prefetch");
    chk("prefetch_pin", prefetch_addr, 13'h124);
    wake_flag <= 9'h001;
    repeat (10) @(posedge clk);
    rdchk(swc_pkg::OFS_STATUS, 32'h16, "status");
    wait_hi(1200, 1'b1);
    chk("warm", (n > 1000 && n < 1030), 1'b1);
    repeat (5) @(negedge clk);
    chk("vec", vec_cnt, 0);
    chk("reset", full_reset_req, 1'b0);
    rdchk(swc_pkg::OFS_EVT, 32'h05, "evt");
    wake_flag <= 9'h000;
    wr(swc_pkg::OFS_EVT, 32'h1f);
    rdchk(swc_pkg::OFS_EVT, 32'h0, "evt");
    @(negedge clk);
    chk("irq", irq, 1'b0);
    // Clocked group and unenabled source stay quiet; then vectored wake.
    wr(swc_pkg::OFS_WAKE_EN, 32'h201);
    wr(swc_pkg::OFS_CTRL, 32'h2);
    i_host.do_sleep(13'h0200);
    clocked_irq_flag <= 1'b1;
    wake_flag        <= 9'h002;
    repeat (50) @(negedge clk);
    chk("run", core_run, 1'b0);
    @(posedge clk);
    clocked_irq_flag <= 1'b0;
    wake_flag        <= 9'h000;
    wr(swc_pkg::OFS_WAKE_EN, 32'h002);
    wake_flag <= 9'h002;
    wait_hi(1200, 1'b1);
    repeat (5) @(negedge clk);
    chk("vec", vec_cnt, 1);
    chk("vaddr", vector_addr, swc_pkg::IRQ_VEC);
    rdchk(swc_pkg::OFS_CTRL, 32'h0, "ctrl");
    // Each clockless peripheral wakes once sleep has completed.
    for (int s = 2; s < 9; s++)
    begin
      wake_flag <= 9'h000;
      wr(swc_pkg::OFS_WAKE_EN, 32'h1 << s);
      i_host.do_sleep(13'h0300);
      wake_flag <= 9'h001 << s;
      repeat (3) @(posedge clk);
      rdchk(swc_pkg::OFS_STATUS, 32'h16, "wake");
      wait_hi(1200, 1'b1);
    end
    // Pending enabled flag with the global enable clear: sleep is a no-op.
    i_host.do_watchdog_clear_instr();
    wr(swc_pkg::OFS_WAKE_EN, 32'h001);
    wake_flag <= 9'h001;
    repeat (4) @(posedge clk);
    wr(swc_pkg::OFS_EVT, 32'h1f);
    i_host.do_sleep(13'h0400);
    repeat (3) @(posedge clk);
    rdchk(swc_pkg::OFS_STATUS, 32'h1c, "nop");
    rdchk(swc_pkg::OFS_EVT, 32'h02, "evt");
    // Watchdog keeps running from the clear done by sleep and wakes.
    wake_flag <= 9'h000;
    wr(swc_pkg::OFS_EVT, 32'h1f);
    i_host.do_watchdog_clear_instr();
    wr(swc_pkg::OFS_CTRL, 32'h1);
    repeat (150) @(posedge clk);
    i_host.do_sleep(13'h0500);
    wait_hi(1000, 1'b0);
    chk("wdt", (n > WDT_N - 10 && n < WDT_N + 30), 1'b1);
    wr(swc_pkg::OFS_CTRL, 32'h0);
    rdchk(swc_pkg::OFS_STATUS, 32'h06, "status");
    wait_hi(1200, 1'b1);
    rdchk(swc_pkg::OFS_EVT, 32'h09, "evt");
    rdchk(swc_pkg::OFS_WAKE_EN, 32'h001, "wake_en");
    chk("reset", full_reset_req, 1'b0);
    // Master clear while asleep gives a full reset.
    wr(swc_pkg::OFS_EVT, 32'h1f);
    i_host.do_sleep(13'h0600);
    repeat (5) @(posedge clk);
    master_clear_pin_b <= 1'b0;
    repeat (5) @(negedge clk);
    chk("reset", {full_reset_req, core_run}, 2'h3);
    @(posedge clk);
    master_clear_pin_b <= 1'b1;
    repeat (5) @(negedge clk);
    chk("reset", full_reset_req, 1'b0);
    rdchk(swc_pkg::OFS_EVT, 32'h11, "evt");
    wr(swc_pkg::OFS_EVT_MASK, 32'h0);
    @(negedge clk);
    chk("irq", irq, 1'b0);
    end_of_test();
  end
endmodule
`default_nettype wire
